// ### sim/framer_global_config_bank_tb.sv
// Testbench for the framer global configuration bank over AXI4-Lite.
// Assumes one 40 MHz clock and the package's register map.
`timescale 1ns/1ps
module framer_global_config_bank_tb;
  logic aclk = 0, aresetn = 0, gpio_in = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, line_standard_select, j1_select, frame_format_invalid;
  logic soft_reset_pulse, gpio_out, gpio_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp, frame_format_field, r;
  logic [9:0] frame_crc_error_count = 0, transmit_side_crc_count = 0;
  logic [9:0] far_end_block_error_count = 0, transmit_side_far_block_count = 0;
  logic [11:0] framing_bit_error_count = 0;
  logic [2:0] alignment_change_count = 0;
  logic [4:0] out_of_frame_count = 0;
  logic [15:0] pattern_detector_count = 0, line_code_violation_count = 0;
  logic [127:0] pmv;
  int fail_count, n_checks, pulses, i, n, p, mdl_lm;
  // Indirect cases: space nibble, entry offset byte, writable mask byte
  int tab [6] = '{'h1011F, 'h11000, 'h21FFF, 'h33FFF, 'h3415F, 'h25000};

  fgc_bank #(.ID_PART(4'h6), .ID_REV(4'h9)) u_fgc_bank (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_crc_error_count,
    .framing_bit_error_count, .alignment_change_count, .out_of_frame_count,
    .pattern_detector_count, .line_code_violation_count, .transmit_side_crc_count,
    .far_end_block_error_count, .transmit_side_far_block_count, .line_standard_select,
    .j1_select, .frame_format_field, .frame_format_invalid, .soft_reset_pulse, .gpio_in,
    .gpio_out, .gpio_oe);

  // Clock, 25 ns period
  always #12.5 aclk = ~aclk;
  // Count software reset pulses
  always @(posedge aclk) if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;

  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic limit(input bit hit);
    if (hit) begin
      fail_count++;
      print_verdict();
    end
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Write cycle: AW and W offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
    int k;
    logic ta, tw, tb;
    // Let an edge pass so the last release of a previous call stands alone
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 0;
    for (k = 0; k < 40 && !tb; k++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready === 1'b1;
      tw = s_axi_wvalid && s_axi_wready === 1'b1;
      tb = s_axi_bready && s_axi_bvalid === 1'b1;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    limit(!tb);
  endtask

  // Read cycle: hold AR until taken, rready until rvalid
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    int k;
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 0;
    for (k = 0; k < 40 && !tr; k++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready === 1'b1;
      tr = s_axi_rready && s_axi_rvalid === 1'b1;
      v = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    limit(!tr);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, d, r);
    chk(e, d);
    chk(32'(er), 32'(r));
  endtask

  // Select an indirect space and entry
  task automatic ind(input logic [1:0] sp, input logic [6:0] o);
    wr(12'h0C0, {22'h0, sp, 1'b0, o}, r);
  endtask

  initial begin
    void'($urandom(52145));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    {frame_crc_error_count, framing_bit_error_count, alignment_change_count,
      out_of_frame_count, pattern_detector_count, line_code_violation_count,
      transmit_side_crc_count, far_end_block_error_count, transmit_side_far_block_count}
      <= 92'({$urandom, $urandom, $urandom});
    gpio_in <= 1'($urandom);
    @(posedge aclk);
    rchk(12'h018, {29'h0, gpio_in, 2'h1}, 2'h0);
    rchk(12'h080, 32'h00, 2'h0);
    rchk(12'h004, 32'h69, 2'h0);
    wr(12'h004, 32'h00, r);
    rchk(12'h004, 32'h69, 2'h0);
    rchk(12'h008, 32'h00, 2'h2);
    // Every line mode code, reserved bits set
    for (i = 0; i < 16; i++) begin
      // line mode programmed before other setup
      wr(12'h080, 32'(i) | 32'hF0, r);
      mdl_lm = i & 'hF;
      rchk(12'h080, 32'(mdl_lm), 2'h0);
      chk(32'(i[0]), 32'(line_standard_select));
      chk(32'(i[0] & i[3]), 32'(j1_select));
      chk(32'(i[0] ? i[2:1] : 2'h0), 32'(frame_format_field));
      chk(32'(i[0] & i[3] & i[2]), 32'(frame_format_invalid));
    end
    // Level only takes while the pin is already an output
    wr(12'h018, 32'h00, r);
    wr(12'h018, 32'h04, r);
    rchk(12'h018, 32'h04, 2'h0);
    chk(32'h1, 32'({gpio_oe, gpio_out} == 2'h3));
    wr(12'h018, 32'h05, r);
    rchk(12'h018, {29'h0, gpio_in, 2'h1}, 2'h0);
    chk(32'h0, 32'(gpio_oe));
    wr(12'h018, 32'h04, r);
    p = pulses;
    s_axi_wstrb <= 4'h0;
    // reset after the mode change, clock running
    wr(12'h010, 32'hA5, r);
    s_axi_wstrb <= 4'hF;
    d = 32'h10000;
    for (n = 0; n < 60 && d[16]; n++) rd(12'h0C0, d, r);
    limit(d[16]);
    chk(p + 1, pulses);
    rchk(12'h018, {29'h0, gpio_in, 2'h1}, 2'h0);
    rchk(12'h080, 32'(mdl_lm), 2'h0);
    // Counter bytes, low byte at even offset
    pmv = {16'(transmit_side_far_block_count), 16'(far_end_block_error_count),
      16'(transmit_side_crc_count), line_code_violation_count, pattern_detector_count,
      8'(out_of_frame_count), 8'(alignment_change_count), 16'(framing_bit_error_count),
      16'(frame_crc_error_count)};
    for (i = 0; i < 16; i++) begin
      ind(2'h0, 7'(i));
      rchk(12'h0C4, 32'(pmv[i*8 +: 8]), 2'h0);
    end
    // Entry masks, cleared by the software reset first
    for (i = 0; i < 6; i++) begin
      ind(2'(tab[i] >> 16), 7'(tab[i] >> 8));
      rchk(12'h0C4, 32'h0, 2'h0);
      wr(12'h0C4, 32'hFF, r);
      rchk(12'h0C4, 32'(tab[i][7:0]), 2'h0);
    end
    wr(12'h008, 32'hFF, r);
    chk(32'h2, 32'(r));
    print_verdict();
  end
endmodule

// ### verilog/fgc_bank.sv
// Global configuration bank of a T1/J1/E1 framer with AXI4-Lite access.
// Assumes one clock, synchronous active-low reset, counters from outside.
`timescale 1ns/1ps
module fgc_bank #(
  // Identification nibbles, values arbitrary
  parameter logic [3:0] ID_PART = 4'hA,
  parameter logic [3:0] ID_REV = 4'h3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Performance monitor counts
  input wire logic [9:0] frame_crc_error_count,
  input wire logic [11:0] framing_bit_error_count,
  input wire logic [2:0] alignment_change_count,
  input wire logic [4:0] out_of_frame_count,
  input wire logic [15:0] pattern_detector_count,
  input wire logic [15:0] line_code_violation_count,
  input wire logic [9:0] transmit_side_crc_count,
  input wire logic [9:0] far_end_block_error_count,
  input wire logic [9:0] transmit_side_far_block_count,
  // Mode outputs
  output logic line_standard_select,
  output logic j1_select,
  output logic [1:0] frame_format_field,
  output logic frame_format_invalid,
  output logic soft_reset_pulse,
  // General pin
  input wire logic gpio_in,
  output logic gpio_out,
  output logic gpio_oe
);

  logic [9:0] aw_idx_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_fire;
  logic wr_byte0;
  logic [9:0] ar_idx_r;
  fgc_pkg::fgc_rd_t rd_state_r;
  fgc_pkg::fgc_rd_t rd_state_nxt;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_value;
  logic rd_mapped;
  logic [7:0] lm_r;
  logic soft_rst_r;
  logic [6:0] ind_addr_r;
  logic [1:0] ind_space_r;
  logic ind_busy;
  logic [7:0] ind_mask;
  logic [7:0] counter_byte;
  logic [7:0] gpio_rdata;
  logic [7:0] mem_rdata [1:3];
  logic [2:0] mem_busy;
  logic [7:0] id_byte;

  assign id_byte = {ID_PART, ID_REV};
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_byte0 = wr_fire && wstrb_r[0];
  assign ind_busy = |mem_busy;
  assign ind_mask = fgc_pkg::entry_mask(ind_space_r, ind_addr_r);

  // Write address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_idx_r <= 10'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[11:2];
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= fgc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      case (aw_idx_r)
        fgc_pkg::IDX_CHIP_IDENTIFICATION, fgc_pkg::IDX_SOFT_RESET, fgc_pkg::IDX_GPIO,
        fgc_pkg::IDX_LINE_MODE, fgc_pkg::IDX_IND_CTRL,
        fgc_pkg::IDX_IND_DATA: bresp_r <= fgc_pkg::RESP_OKAY;
        default: bresp_r <= fgc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // line mode kept across software reset
  // only the bus reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lm_r <= fgc_pkg::LM_RESET;
    end else if (wr_byte0 && aw_idx_r == fgc_pkg::IDX_LINE_MODE) begin
      lm_r <= wdata_r[7:0] & fgc_pkg::LM_MASK;
    end
  end

  // runs on aclk, so it needs the clock present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_fire && aw_idx_r == fgc_pkg::IDX_SOFT_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_standard_select <= 1'b0;
      j1_select <= 1'b0;
      frame_format_field <= fgc_pkg::FMT_SF;
      frame_format_invalid <= 1'b0;
    end else begin
      line_standard_select <= lm_r[fgc_pkg::LM_STD_BIT];
      j1_select <= lm_r[fgc_pkg::LM_STD_BIT] && lm_r[fgc_pkg::LM_J1_BIT];
      frame_format_field <= lm_r[fgc_pkg::LM_STD_BIT] ?
        lm_r[fgc_pkg::LM_FMT_MSB:fgc_pkg::LM_FMT_LSB] : fgc_pkg::FMT_SF;
      frame_format_invalid <= lm_r[fgc_pkg::LM_STD_BIT] && lm_r[fgc_pkg::LM_J1_BIT]
        && lm_r[fgc_pkg::LM_FMT_MSB];
    end
  end

  assign soft_reset_pulse = soft_rst_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst_r) begin
      ind_addr_r <= 7'h00;
      ind_space_r <= fgc_pkg::SPACE_COUNTERS;
    end else if (wr_byte0 && aw_idx_r == fgc_pkg::IDX_IND_CTRL) begin
      ind_addr_r <= wdata_r[fgc_pkg::IND_ADDR_MSB:fgc_pkg::IND_ADDR_LSB];
      if (wstrb_r[1]) begin
        ind_space_r <= wdata_r[fgc_pkg::IND_SPACE_MSB:fgc_pkg::IND_SPACE_LSB];
      end
    end
  end

  // General pin
  fgc_gpio u_gpio (
    .aclk(aclk),
    .aresetn(aresetn),
    .soft_reset(soft_rst_r),
    .wr_en(wr_byte0 && aw_idx_r == fgc_pkg::IDX_GPIO),
    .wdata(wdata_r[7:0]),
    .rdata(gpio_rdata),
    .gpio_in(gpio_in),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe)
  );

  genvar gi;
  for (gi = 1; gi < 4; gi++) begin : g_space
    logic mem_wr;
    // reserved bits and missing entries dropped
    assign mem_wr = wr_byte0 && aw_idx_r == fgc_pkg::IDX_IND_DATA && !ind_busy
      && ind_space_r == 2'(gi) && ind_mask != fgc_pkg::NO_BITS;
    fgc_entry_ram u_ram (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear_req(soft_rst_r),
      .clear_busy(mem_busy[gi-1]),
      .wr_en(mem_wr),
      .addr(ind_addr_r),
      .wdata(wdata_r[7:0] & ind_mask),
      .rdata(mem_rdata[gi])
    );
  end

  always_comb begin
    counter_byte = 8'h00;
    if (ind_addr_r[6:4] == 3'h0) begin
      case (ind_addr_r[3:0])
        fgc_pkg::CNT_CRC_LO: counter_byte = frame_crc_error_count[7:0];
        fgc_pkg::CNT_CRC_HI: counter_byte = {6'h00, frame_crc_error_count[9:8]};
        fgc_pkg::CNT_FRAMING_LO: counter_byte = framing_bit_error_count[7:0];
        fgc_pkg::CNT_FRAMING_HI: counter_byte = {4'h0, framing_bit_error_count[11:8]};
        fgc_pkg::CNT_ALIGN: counter_byte = {5'h00, alignment_change_count};
        fgc_pkg::CNT_OUT_OF_FRAME: counter_byte = {3'h0, out_of_frame_count};
        fgc_pkg::CNT_PATTERN_LO: counter_byte = pattern_detector_count[7:0];
        fgc_pkg::CNT_PATTERN_HI: counter_byte = pattern_detector_count[15:8];
        fgc_pkg::CNT_VIOLATION_LO: counter_byte = line_code_violation_count[7:0];
        fgc_pkg::CNT_VIOLATION_HI: counter_byte = line_code_violation_count[15:8];
        fgc_pkg::CNT_TX_CRC_LO: counter_byte = transmit_side_crc_count[7:0];
        fgc_pkg::CNT_TX_CRC_HI: counter_byte = {6'h00, transmit_side_crc_count[9:8]};
        fgc_pkg::CNT_FAR_LO: counter_byte = far_end_block_error_count[7:0];
        fgc_pkg::CNT_FAR_HI: counter_byte = {6'h00, far_end_block_error_count[9:8]};
        fgc_pkg::CNT_TX_FAR_LO: counter_byte = transmit_side_far_block_count[7:0];
        fgc_pkg::CNT_TX_FAR_HI: counter_byte = {6'h00, transmit_side_far_block_count[9:8]};
        default: counter_byte = 8'h00;
      endcase
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (ar_idx_r)
      fgc_pkg::IDX_CHIP_IDENTIFICATION: rd_value[7:0] = id_byte;
      fgc_pkg::IDX_SOFT_RESET: rd_value = 32'h0000_0000;
      fgc_pkg::IDX_GPIO: rd_value[7:0] = gpio_rdata;
      fgc_pkg::IDX_LINE_MODE: rd_value[7:0] = lm_r;
      fgc_pkg::IDX_IND_CTRL: begin
        rd_value[fgc_pkg::IND_ADDR_MSB:fgc_pkg::IND_ADDR_LSB] = ind_addr_r;
        rd_value[fgc_pkg::IND_SPACE_MSB:fgc_pkg::IND_SPACE_LSB] = ind_space_r;
        rd_value[fgc_pkg::IND_BUSY_BIT] = ind_busy;
      end
      fgc_pkg::IDX_IND_DATA: begin
        if (ind_space_r == fgc_pkg::SPACE_COUNTERS) begin
          rd_value[7:0] = counter_byte;
        end else if (!ind_busy) begin
          rd_value[7:0] = mem_rdata[ind_space_r] & ind_mask;
        end
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  // Read state: fetch cycle lets the entry memory settle
  always_comb begin
    rd_state_nxt = rd_state_r;
    case (rd_state_r)
      fgc_pkg::RD_IDLE: if (s_axi_arvalid) rd_state_nxt = fgc_pkg::RD_FETCH;
      fgc_pkg::RD_FETCH: rd_state_nxt = fgc_pkg::RD_RESP;
      fgc_pkg::RD_RESP: if (s_axi_rready) rd_state_nxt = fgc_pkg::RD_IDLE;
      default: rd_state_nxt = fgc_pkg::RD_IDLE;
    endcase
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= fgc_pkg::RD_IDLE;
      ar_idx_r <= 10'h000;
      rdata_r <= 32'h0000_0000;
      rresp_r <= fgc_pkg::RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      if (rd_state_r == fgc_pkg::RD_IDLE && s_axi_arvalid) begin
        ar_idx_r <= s_axi_araddr[11:2];
      end
      if (rd_state_r == fgc_pkg::RD_FETCH) begin
        rdata_r <= rd_value;
        rresp_r <= rd_mapped ? fgc_pkg::RESP_OKAY : fgc_pkg::RESP_SLVERR;
      end
    end
  end

  assign s_axi_arready = rd_state_r == fgc_pkg::RD_IDLE;
  assign s_axi_rvalid = rd_state_r == fgc_pkg::RD_RESP;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Checks
  a_srst_any: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && aw_idx_r == fgc_pkg::IDX_SOFT_RESET |=> soft_reset_pulse)
    else $error("write to reset register gave no reset");
  a_mode_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_rst_r |=> $stable(lm_r)) else $error("line mode lost on soft reset");
  a_sel_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_rst_r |=> ind_addr_r == 7'h00 && ind_busy) else $error("no default after reset");
  a_id_read: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_state_r == fgc_pkg::RD_FETCH && ar_idx_r == fgc_pkg::IDX_CHIP_IDENTIFICATION
    |=> s_axi_rvalid && s_axi_rdata == {24'h000000, ID_PART, ID_REV})
    else $error("identification byte wrong");
  a_std_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_byte0 && aw_idx_r == fgc_pkg::IDX_LINE_MODE
    |=> ##1 line_standard_select == $past(wdata_r[0], 2)) else $error("standard not set");
  a_j1_e1: assert property (@(posedge aclk) disable iff (!aresetn)
    !lm_r[fgc_pkg::LM_STD_BIT] |=> !j1_select && frame_format_field == fgc_pkg::FMT_SF)
    else $error("variant bits active in E1");
  a_fmt_only_t1: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_format_invalid |-> j1_select && frame_format_field[1])
    else $error("format flagged wrongly");
  a_rsv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:17] == 15'h0000) else $error("reserved bits set");
  a_ext_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && ar_idx_r == fgc_pkg::IDX_IND_DATA
    && ind_space_r == fgc_pkg::SPACE_RX_EXTRACT |-> s_axi_rdata[7:5] == 3'h0)
    else $error("extract entry reserved bits set");
  a_sig_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && ar_idx_r == fgc_pkg::IDX_IND_DATA && ind_space_r[1] && ind_addr_r[6]
    |-> s_axi_rdata[7] == 1'b0 && s_axi_rdata[5] == 1'b0)
    else $error("signaling entry reserved bits set");

  c_write_done: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready);
  c_soft_reset: cover property (@(posedge aclk) disable iff (!aresetn) soft_reset_pulse);
  c_pin_input: cover property (@(posedge aclk) disable iff (!aresetn)
    !gpio_oe && s_axi_rvalid && ar_idx_r == fgc_pkg::IDX_GPIO);

endmodule

// ### verilog/fgc_entry_ram.sv
// Byte-wide entry memory for one indirect space, 128 words.
// Assumes the caller masks data; a clear request sweeps every word to zero.
`timescale 1ns/1ps
module fgc_entry_ram (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Clear sweep
  input wire logic clear_req,
  output logic clear_busy,
  // Access port
  input wire logic wr_en,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:127];
  logic [6:0] clr_cnt_r;
  logic clr_act_r;

  // Clear sweep counter
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_req) begin
      clr_act_r <= clear_req;
      clr_cnt_r <= 7'h00;
    end else if (clr_act_r) begin
      clr_cnt_r <= clr_cnt_r + 7'h01;
      if (clr_cnt_r == fgc_pkg::ENTRY_LAST) begin
        clr_act_r <= 1'b0;
      end
    end
  end

  // Sweep writes win over bus writes
  always_ff @(posedge aclk) begin
    if (clr_act_r) begin
      mem[clr_cnt_r] <= 8'h00;
    end else if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[addr];
    end
  end

  assign clear_busy = clr_act_r;

  a_clear_start: assert property (@(posedge aclk) disable iff (!aresetn)
    clear_req |=> clear_busy) else $error("clear sweep did not start");

endmodule

// ### verilog/fgc_gpio.sv
// General pin with direction and level control.
// Assumes the pin input is synchronous to aclk; the pad is resolved outside.
`timescale 1ns/1ps
module fgc_gpio (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset,
  // Register access
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Pin
  input wire logic gpio_in,
  output logic gpio_out,
  output logic gpio_oe
);

  logic dir_r;
  logic level_r;
  logic pin_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      dir_r <= fgc_pkg::GPIO_RESET[fgc_pkg::GPIO_DIR_BIT];
    end else if (wr_en) begin
      dir_r <= wdata[fgc_pkg::GPIO_DIR_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      level_r <= fgc_pkg::GPIO_RESET[fgc_pkg::GPIO_LEVEL_BIT];
    end else if (wr_en && !dir_r) begin
      level_r <= wdata[fgc_pkg::GPIO_LEVEL_BIT];
    end
  end

  // Pin sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= gpio_in;
    end
  end

  always_comb begin
    rdata = 8'h00;
    rdata[fgc_pkg::GPIO_DIR_BIT] = dir_r;
    rdata[fgc_pkg::GPIO_LEVEL_BIT] = dir_r ? pin_r : level_r;
  end

  assign gpio_out = level_r;
  assign gpio_oe = !dir_r;

  a_dir_default: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_reset |=> !gpio_oe) else $error("pin not input after reset");
  a_out_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && !dir_r && !soft_reset |=> gpio_out == $past(wdata[fgc_pkg::GPIO_LEVEL_BIT]))
    else $error("pin level not driven");
  a_in_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && dir_r && !soft_reset |=> $stable(level_r))
    else $error("level written in input mode");

endmodule

// ### verilog/fgc_pkg.sv
// Package for the framer global configuration bank: register indices,
// field positions, reset values, indirect space codes and masks.
// Assumes an AXI4-Lite slave with 32-bit data; byte address = 4 * index.
package fgc_pkg;

  // Direct register indices
  localparam logic [9:0] IDX_CHIP_IDENTIFICATION = 10'h001;
  localparam logic [9:0] IDX_SOFT_RESET = 10'h004;
  localparam logic [9:0] IDX_GPIO = 10'h006;
  localparam logic [9:0] IDX_LINE_MODE = 10'h020;
  localparam logic [9:0] IDX_IND_CTRL = 10'h030;
  localparam logic [9:0] IDX_IND_DATA = 10'h031;

  // Line mode fields
  localparam int LM_STD_BIT = 0;
  localparam int LM_FMT_LSB = 1;
  localparam int LM_FMT_MSB = 2;
  localparam int LM_J1_BIT = 3;
  localparam logic [7:0] LM_MASK = 8'h0F;
  localparam logic [7:0] LM_RESET = 8'h00;

  // Frame format codes in T1/J1
  localparam logic [1:0] FMT_SF = 2'h0;
  localparam logic [1:0] FMT_ESF = 2'h1;

  // General pin fields
  localparam int GPIO_DIR_BIT = 0;
  localparam int GPIO_LEVEL_BIT = 2;
  localparam logic [7:0] GPIO_RESET = 8'h01;

  // Indirect control fields
  localparam int IND_ADDR_LSB = 0;
  localparam int IND_ADDR_MSB = 6;
  localparam int IND_SPACE_LSB = 8;
  localparam int IND_SPACE_MSB = 9;
  localparam int IND_BUSY_BIT = 16;

  // Indirect space codes
  localparam logic [1:0] SPACE_COUNTERS = 2'h0;
  localparam logic [1:0] SPACE_RX_EXTRACT = 2'h1;
  localparam logic [1:0] SPACE_RX_COND = 2'h2;
  localparam logic [1:0] SPACE_TX_COND = 2'h3;

  // Performance monitor byte offsets
  localparam logic [3:0] CNT_CRC_LO = 4'h0;
  localparam logic [3:0] CNT_CRC_HI = 4'h1;
  localparam logic [3:0] CNT_FRAMING_LO = 4'h2;
  localparam logic [3:0] CNT_FRAMING_HI = 4'h3;
  localparam logic [3:0] CNT_ALIGN = 4'h4;
  localparam logic [3:0] CNT_OUT_OF_FRAME = 4'h5;
  localparam logic [3:0] CNT_PATTERN_LO = 4'h6;
  localparam logic [3:0] CNT_PATTERN_HI = 4'h7;
  localparam logic [3:0] CNT_VIOLATION_LO = 4'h8;
  localparam logic [3:0] CNT_VIOLATION_HI = 4'h9;
  localparam logic [3:0] CNT_TX_CRC_LO = 4'hA;
  localparam logic [3:0] CNT_TX_CRC_HI = 4'hB;
  localparam logic [3:0] CNT_FAR_LO = 4'hC;
  localparam logic [3:0] CNT_FAR_HI = 4'hD;
  localparam logic [3:0] CNT_TX_FAR_LO = 4'hE;
  localparam logic [3:0] CNT_TX_FAR_HI = 4'hF;

  // Entry masks
  localparam logic [7:0] EXT_MASK = 8'h1F;
  localparam logic [7:0] COND_MASK = 8'hFF;
  localparam logic [7:0] SIG_MASK = 8'h5F;
  localparam logic [7:0] NO_BITS = 8'h00;

  // Entry memory size and clear sweep length
  localparam int ENTRY_AW = 7;
  localparam logic [6:0] ENTRY_LAST = 7'h7F;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Read channel states
  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} fgc_rd_t;

  // Writable bits of an indirect entry, zero where no entry exists
  function automatic logic [7:0] entry_mask(input logic [1:0] space, input logic [6:0] a);
    logic [7:0] m;
    m = NO_BITS;
    if (space == SPACE_RX_EXTRACT) begin
      if (a[6:5] == 2'h0 && a[3:0] != 4'h0) begin
        m = EXT_MASK;
      end
    end else if (space != SPACE_COUNTERS) begin
      if (!a[6]) begin
        m = COND_MASK;
      end else if (!a[5] && a[3:0] != 4'h0) begin
        m = SIG_MASK;
      end
    end
    return m;
  endfunction

endpackage
